// [src/bpm_defs.vh]
// Register map, field positions and reset values of the breakpoint block.
`ifndef BPM_DEFS_VH
`define BPM_DEFS_VH

// ****************************************
// Register byte offsets, region codes and word indices
// ****************************************
`define BPM_ADR_W 12
`define BPM_INST_STATUS 12'h000
`define BPM_DATA_STATUS 12'h004
`define BPM_REG_INST 4'h1
`define BPM_REG_DATA 4'h2
`define BPM_OFS_ADDR 2'h0
`define BPM_OFS_MASK 2'h1
`define BPM_OFS_CTRL 2'h2
`define BPM_OFS_VAL 2'h3

// ****************************************
// Control and status field positions
// ****************************************
`define BPM_BRK_EN 0
`define BPM_TRIG_EN 2
`define BPM_IVM 1
`define BPM_ICTL_RANGE 4
`define BPM_ICTL_EXCL 5
`define BPM_ICTL_PRESET 6
`define BPM_DCTL_LANE_MASK 4
`define BPM_DCTL_NOLOAD 12
`define BPM_DCTL_NOSTORE 13
`define BPM_DCTL_LANE_IGN 14
`define BPM_DCTL_RANGE 8
`define BPM_DCTL_EXCL 9
`define BPM_DCTL_PRESET 10
`define BPM_NUM_CHAN 24

// ****************************************
// Reset values and access sizes
// ****************************************
`define BPM_CTRL_RST 32'h0000_0000
`define BPM_SIZE_BYTE 2'h0
`define BPM_SIZE_HALF 2'h1

`endif

// [src/bpm_match.v]
// Hardware breakpoint matching, status and debug exception logic.
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "bpm_defs.vh"

module bpm_match #(
  parameter NI = 2,
  parameter ND = 1,
  parameter IB_RANGE = 1,
  parameter DB_RANGE = 1
) (
  input wire CLOCK,
  input wire NRST,
  // Classic Wishbone slave.
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [11:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Core state.
  input wire DEBUG_MODE,
  // Executed instruction.
  input wire I_VALID,
  input wire [31:0] I_PC,
  input wire I_LONG,
  input wire I_DELAY_SLOT,
  // Executed explicit load or store.
  input wire D_VALID,
  input wire D_LOAD,
  input wire [31:0] D_PC,
  input wire D_DELAY_SLOT,
  input wire [31:0] D_ADDR,
  input wire [1:0] D_SIZE,
  input wire [31:0] D_DATA,
  // Debug exception results.
  output reg INST_BREAK,
  output reg INST_KILL,
  output reg DATA_BREAK,
  output reg BLOCK_STORE,
  output reg BLOCK_LOAD,
  output reg NO_WRITEBACK,
  output reg [31:0] DEBUG_EXCEPTION_PC,
  output reg DEBUG_BRANCH_DELAY_FLAG
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Lanes touched by an access of the given size and address.
  function [3:0] lanes_of;
    input [1:0] size;
    input [1:0] lo;
    begin
      if (size == `BPM_SIZE_BYTE) begin
        lanes_of = 4'h1 << lo;
      end else if (size == `BPM_SIZE_HALF) begin
        lanes_of = lo[1] ? 4'hc : 4'h3;
      end else begin
        lanes_of = 4'hf;
      end
    end
  endfunction

  // Merge write data into a register under byte enables.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[8*k +: 8] = wd[8*k +: 8];
        end
      end
    end
  endfunction

  // Range test of span first..last against lo..up, either sense.
  // Spans crossing a limit give true in both senses.
  function in_range;
    input [31:0] first;
    input [31:0] last;
    input [31:0] lo;
    input [31:0] up;
    input excl;
    begin
      if (excl) begin
        in_range = (first < lo) || (last > up);
      end else begin
        in_range = (first <= up) && (last >= lo);
      end
    end
  endfunction

  // ****************************************
  // Breakpoint registers
  // ****************************************

  // Per-channel address, mask, control and value words.
  reg [31:0] inst_bp_addr [0:NI-1];
  reg [31:0] inst_bp_mask [0:NI-1];
  reg [31:0] inst_bp_control [0:NI-1];
  reg [31:0] data_bp_addr [0:ND-1];
  reg [31:0] data_bp_mask [0:ND-1];
  reg [31:0] data_bp_control [0:ND-1];
  reg [31:0] data_bp_value [0:ND-1];
  // Sticky status bits, one per channel.
  reg [NI-1:0] inst_break_status;
  reg [ND-1:0] data_break_status;

  // Decoded bus request.
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = req & WB_WE_I;
  wire [3:0] region = WB_ADR_I[11:8];
  wire [3:0] chan = WB_ADR_I[7:4];
  wire [1:0] word = WB_ADR_I[3:2];

  // Masks of writable control bits; range bits only if supported.
  wire [31:0] inst_ctl_wmask = (32'h1 << `BPM_BRK_EN) | (32'h1 << `BPM_TRIG_EN)
    | (IB_RANGE ? ((32'h1 << `BPM_ICTL_RANGE)
    | (32'h1 << `BPM_ICTL_EXCL)) : 32'h0);
  wire [31:0] data_ctl_wmask = 32'h0003_f0f7
    | (DB_RANGE ? ((32'h1 << `BPM_DCTL_RANGE)
    | (32'h1 << `BPM_DCTL_EXCL)) : 32'h0);

  // ****************************************
  // Instruction match
  // ****************************************

  reg [NI-1:0] i_hit;
  reg [NI-1:0] i_exc;
  reg [31:0] i_first;
  reg [31:0] i_last;
  integer a;

  // Every enabled channel is checked against the executed PC.
  always @* begin
    i_hit = {NI{1'b0}};
    i_exc = {NI{1'b0}};
    // Halfword granularity; a long instruction covers two.
    i_first = {1'b0, I_PC[31:1]};
    i_last = i_first + {31'h0, I_LONG};
    for (a = 0; a < NI; a = a + 1) begin
      if (inst_bp_control[a][`BPM_ICTL_RANGE]) begin
        // Address is the upper limit, mask the lower.
        i_hit[a] = in_range(i_first, i_last,
          {1'b0, inst_bp_mask[a][31:1]}, {1'b0, inst_bp_addr[a][31:1]},
          inst_bp_control[a][`BPM_ICTL_EXCL]);
      end else begin
        i_hit[a] = &(inst_bp_mask[a] | ~(I_PC ^ inst_bp_addr[a]));
      end
      // Only executed, non-debug instructions are checked.
      i_hit[a] = i_hit[a] & I_VALID & ~DEBUG_MODE
        & (inst_bp_control[a][`BPM_BRK_EN] | inst_bp_control[a][`BPM_TRIG_EN]);
      i_exc[a] = i_hit[a] & inst_bp_control[a][`BPM_BRK_EN];
    end
  end

  wire inst_exc = |i_exc;

  // ****************************************
  // Data match
  // ****************************************

  wire [3:0] accessed_lanes = lanes_of(D_SIZE, D_ADDR[1:0]);
  wire [1:0] lane_lo = accessed_lanes[0] ? 2'h0 :
    accessed_lanes[1] ? 2'h1 : accessed_lanes[2] ? 2'h2 : 2'h3;
  wire [1:0] lane_hi = accessed_lanes[3] ? 2'h3 :
    accessed_lanes[2] ? 2'h2 : accessed_lanes[1] ? 2'h1 : 2'h0;
  // First and last byte actually touched by the access.
  wire [31:0] d_first = {D_ADDR[31:2], lane_lo};
  wire [31:0] d_last = {D_ADDR[31:2], lane_hi};
  // An instruction killed by its own instruction break moves no data.
  wire d_eval = D_VALID & ~DEBUG_MODE
    & ~(I_VALID & inst_exc);

  reg [ND-1:0] d_hit;
  reg [ND-1:0] skip_value_compare;
  reg [3:0] byte_lane_mask;
  reg [3:0] byte_access_ignore;
  reg [31:0] cmp_mask;
  reg addr_ok;
  reg value_ok;
  integer b;
  integer m;

  // Address, type and value terms of each data channel.
  always @* begin
    d_hit = {ND{1'b0}};
    skip_value_compare = {ND{1'b0}};
    byte_lane_mask = 4'h0;
    byte_access_ignore = 4'h0;
    cmp_mask = 32'h0;
    addr_ok = 1'b0;
    value_ok = 1'b0;
    for (b = 0; b < ND; b = b + 1) begin
      byte_lane_mask = data_bp_control[b][`BPM_DCTL_LANE_MASK +: 4];
      byte_access_ignore = data_bp_control[b][`BPM_DCTL_LANE_IGN +: 4];
      if (data_bp_control[b][`BPM_DCTL_RANGE]) begin
        // Address is the upper limit, mask the lower.
        addr_ok = in_range(d_first, d_last, data_bp_mask[b], data_bp_addr[b],
          data_bp_control[b][`BPM_DCTL_EXCL]);
      end else begin
        addr_ok = (&(data_bp_mask[b][31:2] | ~(D_ADDR[31:2] ^ data_bp_addr[b][31:2])))
          & (|(accessed_lanes & ~byte_access_ignore));
      end
      skip_value_compare[b] = &(byte_lane_mask | byte_access_ignore
        | ~accessed_lanes);
      // Raw bus bytes that take part in the compare.
      for (m = 0; m < 4; m = m + 1) begin
        cmp_mask[8*m +: 8] = {8{accessed_lanes[m]
          & ~byte_lane_mask[m] & ~byte_access_ignore[m]}};
      end
      value_ok = ~|((D_DATA ^ data_bp_value[b]) & cmp_mask);
      if (data_bp_control[b][`BPM_IVM]) begin
        value_ok = ~value_ok;
      end
      // Range mode relies on software masking every lane.
      d_hit[b] = d_eval & addr_ok
        & (skip_value_compare[b] | value_ok)
        & (D_LOAD ? ~data_bp_control[b][`BPM_DCTL_NOLOAD]
        : ~data_bp_control[b][`BPM_DCTL_NOSTORE])
        & (data_bp_control[b][`BPM_BRK_EN] | data_bp_control[b][`BPM_TRIG_EN]);
    end
  end

  // Exception groups split by whether the value was compared.
  reg [ND-1:0] d_be;
  integer e;
  always @* begin
    d_be = {ND{1'b0}};
    for (e = 0; e < ND; e = e + 1) begin
      d_be[e] = data_bp_control[e][`BPM_BRK_EN];
    end
  end

  wire [ND-1:0] d_plain = d_hit & skip_value_compare;
  wire [ND-1:0] d_valued = d_hit & ~skip_value_compare;
  wire exc_plain = |(d_plain & d_be);
  wire exc_valued = |(d_valued & d_be);
  wire data_exc = exc_plain | exc_valued;
  // A load stopped by an uncompared match returns no valid value.
  wire [ND-1:0] d_set = d_plain
    | ((D_LOAD & exc_plain) ? {ND{1'b0}} : d_valued);

  // ****************************************
  // Status registers and bus slave
  // ****************************************

  reg [31:0] rd;
  integer r;

  // Read multiplexer; unmapped words read as zero.
  always @* begin
    rd = 32'h0;
    if (region == 4'h0 && chan == 4'h0) begin
      if (word == `BPM_INST_STATUS >> 2) begin
        rd[`BPM_NUM_CHAN +: 4] = NI[3:0];
        rd[NI-1:0] = inst_break_status;
      end else if (word == `BPM_DATA_STATUS >> 2) begin
        rd[`BPM_NUM_CHAN +: 4] = ND[3:0];
        rd[ND-1:0] = data_break_status;
      end
    end
    for (r = 0; r < NI; r = r + 1) begin
      if (region == `BPM_REG_INST && chan == r) begin
        case (word)
          `BPM_OFS_ADDR: rd = inst_bp_addr[r];
          `BPM_OFS_MASK: rd = inst_bp_mask[r];
          `BPM_OFS_CTRL: begin
            rd = inst_bp_control[r];
            rd[`BPM_ICTL_PRESET] = (IB_RANGE != 0);
          end
          default: rd = 32'h0;
        endcase
      end
    end
    for (r = 0; r < ND; r = r + 1) begin
      if (region == `BPM_REG_DATA && chan == r) begin
        case (word)
          `BPM_OFS_ADDR: rd = data_bp_addr[r];
          `BPM_OFS_MASK: rd = data_bp_mask[r];
          `BPM_OFS_CTRL: begin
            rd = data_bp_control[r];
            rd[`BPM_DCTL_PRESET] = (DB_RANGE != 0);
          end
          default: rd = data_bp_value[r];
        endcase
      end
    end
  end

  // Status words as a bus write would leave them, before new hits.
  wire [31:0] inst_status_wr = merge({{(32-NI){1'b0}}, inst_break_status},
    WB_DAT_I, WB_SEL_I);
  wire [31:0] data_status_wr = merge({{(32-ND){1'b0}}, data_break_status},
    WB_DAT_I, WB_SEL_I);

  integer w;

  // Register writes; a new match beats a clearing write.
  always @(posedge CLOCK) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      inst_break_status <= {NI{1'b0}};
      data_break_status <= {ND{1'b0}};
      for (w = 0; w < NI; w = w + 1) begin
        inst_bp_addr[w] <= 32'h0;
        inst_bp_mask[w] <= 32'h0;
        inst_bp_control[w] <= `BPM_CTRL_RST;
      end
      for (w = 0; w < ND; w = w + 1) begin
        data_bp_addr[w] <= 32'h0;
        data_bp_mask[w] <= 32'h0;
        data_bp_control[w] <= `BPM_CTRL_RST;
        data_bp_value[w] <= 32'h0;
      end
    end else begin
      // One wait state: ack the cycle after the request.
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd : 32'h0;
      // Status bits are sticky; only a write clears them.
      if (wr && region == 4'h0 && chan == 4'h0
          && word == `BPM_INST_STATUS >> 2) begin
        inst_break_status <= inst_status_wr[NI-1:0] | i_hit;
      end else begin
        inst_break_status <= inst_break_status | i_hit;
      end
      if (wr && region == 4'h0 && chan == 4'h0
          && word == `BPM_DATA_STATUS >> 2) begin
        data_break_status <= data_status_wr[ND-1:0] | d_set;
      end else begin
        data_break_status <= data_break_status | d_set;
      end
      for (w = 0; w < NI; w = w + 1) begin
        if (wr && region == `BPM_REG_INST && chan == w) begin
          case (word)
            `BPM_OFS_ADDR: inst_bp_addr[w] <= merge(inst_bp_addr[w], WB_DAT_I, WB_SEL_I);
            `BPM_OFS_MASK: inst_bp_mask[w] <= merge(inst_bp_mask[w], WB_DAT_I, WB_SEL_I);
            `BPM_OFS_CTRL: inst_bp_control[w] <= merge(inst_bp_control[w], WB_DAT_I,
              WB_SEL_I) & inst_ctl_wmask;
            default: inst_bp_control[w] <= inst_bp_control[w];
          endcase
        end
      end
      for (w = 0; w < ND; w = w + 1) begin
        if (wr && region == `BPM_REG_DATA && chan == w) begin
          case (word)
            `BPM_OFS_ADDR: data_bp_addr[w] <= merge(data_bp_addr[w], WB_DAT_I, WB_SEL_I);
            `BPM_OFS_MASK: data_bp_mask[w] <= merge(data_bp_mask[w], WB_DAT_I, WB_SEL_I);
            `BPM_OFS_CTRL: data_bp_control[w] <= merge(data_bp_control[w], WB_DAT_I,
              WB_SEL_I) & data_ctl_wmask;
            default: data_bp_value[w] <= merge(data_bp_value[w], WB_DAT_I, WB_SEL_I);
          endcase
        end
      end
    end
  end

  // ****************************************
  // Exception outputs
  // ****************************************

  // Flags are one-cycle pulses, one edge after the checked cycle; the PC and delay flag hold between breaks.
  always @(posedge CLOCK) begin
    if (!NRST) begin
      INST_BREAK <= 1'b0;
      INST_KILL <= 1'b0;
      DATA_BREAK <= 1'b0;
      BLOCK_STORE <= 1'b0;
      BLOCK_LOAD <= 1'b0;
      NO_WRITEBACK <= 1'b0;
      DEBUG_EXCEPTION_PC <= 32'h0;
      DEBUG_BRANCH_DELAY_FLAG <= 1'b0;
    end else begin
      INST_BREAK <= inst_exc;
      // The killed instruction updates nothing and moves no data.
      INST_KILL <= inst_exc;
      DATA_BREAK <= data_exc;
      BLOCK_STORE <= data_exc & ~D_LOAD;
      // A compared load still completes from memory.
      BLOCK_LOAD <= exc_plain & D_LOAD;
      NO_WRITEBACK <= data_exc;
      if (I_VALID && inst_exc) begin
        DEBUG_EXCEPTION_PC <= I_PC;
        DEBUG_BRANCH_DELAY_FLAG <= I_DELAY_SLOT;
      end else if (data_exc) begin
        DEBUG_EXCEPTION_PC <= D_PC;
        DEBUG_BRANCH_DELAY_FLAG <= D_DELAY_SLOT;
      end
    end
  end

endmodule
`default_nettype wire

// [verif/bpm_chk.sv]
// Port-level checker for the breakpoint matching block.
`timescale 1ns/10ps
`default_nettype none

// ****
// Checker
// ****
module bpm_chk (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic DEBUG_MODE,
  input wire logic I_VALID,
  input wire logic [31:0] I_PC,
  input wire logic I_DELAY_SLOT,
  input wire logic D_VALID,
  input wire logic D_LOAD,
  input wire logic INST_BREAK,
  input wire logic INST_KILL,
  input wire logic DATA_BREAK,
  input wire logic BLOCK_STORE,
  input wire logic BLOCK_LOAD,
  input wire logic NO_WRITEBACK,
  input wire logic [31:0] DEBUG_EXCEPTION_PC,
  input wire logic DEBUG_BRANCH_DELAY_FLAG
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged next cycle");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  chk_kill_pair: assert property (INST_BREAK == INST_KILL)
    else $error("instruction break without kill");
  chk_inst_cause: assert property (INST_BREAK |-> $past(I_VALID) && !$past(DEBUG_MODE))
    else $error("instruction break without an executed instruction");
  chk_inst_pc: assert property (INST_BREAK |-> DEBUG_EXCEPTION_PC == $past(I_PC)
    && DEBUG_BRANCH_DELAY_FLAG == $past(I_DELAY_SLOT)) else $error("break pc wrong");
  chk_data_cause: assert property (DATA_BREAK |-> $past(D_VALID) && !$past(DEBUG_MODE))
    else $error("data break without an access");
  chk_inst_first: assert property (INST_BREAK |-> !DATA_BREAK)
    else $error("data break on a killed instruction");
  chk_store_block: assert property (DATA_BREAK && !$past(D_LOAD) |-> BLOCK_STORE
    && !BLOCK_LOAD && NO_WRITEBACK) else $error("store break not blocked");
  chk_block_cause: assert property (BLOCK_STORE || BLOCK_LOAD |-> DATA_BREAK && NO_WRITEBACK)
    else $error("blocking without a data break");
  chk_pc_hold: assert property (!INST_BREAK && !DATA_BREAK |-> $stable(DEBUG_EXCEPTION_PC))
    else $error("break pc changed without a break");

  // The main scenarios that the bench must reach.
  cover property (INST_BREAK && DEBUG_BRANCH_DELAY_FLAG);
  cover property (DATA_BREAK && BLOCK_LOAD);
  cover property (DATA_BREAK && !BLOCK_LOAD && $past(D_LOAD));
endmodule

bind bpm_match bpm_chk i_bpm_chk (.CLOCK(CLOCK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .DEBUG_MODE(DEBUG_MODE), .I_VALID(I_VALID),
  .I_PC(I_PC), .I_DELAY_SLOT(I_DELAY_SLOT), .D_VALID(D_VALID), .D_LOAD(D_LOAD),
  .INST_BREAK(INST_BREAK), .INST_KILL(INST_KILL), .DATA_BREAK(DATA_BREAK),
  .BLOCK_STORE(BLOCK_STORE), .BLOCK_LOAD(BLOCK_LOAD), .NO_WRITEBACK(NO_WRITEBACK),
  .DEBUG_EXCEPTION_PC(DEBUG_EXCEPTION_PC), .DEBUG_BRANCH_DELAY_FLAG(DEBUG_BRANCH_DELAY_FLAG));
`default_nettype wire

// [verif/bpm_pipe.sv]
// Behavioural model of the execution pipeline that feeds the block.
`timescale 1ns/10ps
`default_nettype none

// ****
// Pipeline model
// ****
module bpm_pipe (
  input wire logic CLOCK,
  output var logic I_VALID,
  output var logic [31:0] I_PC,
  output var logic I_LONG,
  output var logic I_DELAY_SLOT,
  output var logic D_VALID,
  output var logic D_LOAD,
  output var logic [31:0] D_PC,
  output var logic D_DELAY_SLOT,
  output var logic [31:0] D_ADDR,
  output var logic [1:0] D_SIZE,
  output var logic [31:0] D_DATA
);
  // Quiet at time zero; I_PC, D_ADDR and D_DATA show scrambled values when idle, D_PC only until the first access.
  initial begin
    {I_VALID, I_LONG, I_DELAY_SLOT, D_VALID, D_LOAD, D_DELAY_SLOT} = 6'h00;
    {I_PC, D_PC, D_ADDR, D_DATA} = {4{32'h5a5a_5a5a}};
    D_SIZE = 2'h0;
  end

  // One executed instruction, one cycle long.
  task automatic ins(input logic [31:0] pc, input logic lng, input logic ds);
    @(posedge CLOCK);
    I_VALID <= 1'b1;
    I_PC <= pc;
    I_LONG <= lng;
    I_DELAY_SLOT <= ds;
    @(posedge CLOCK);
    I_VALID <= 1'b0;
    I_PC <= ~pc;
  endtask

  // Only explicit loads and stores are ever presented.
  task automatic dat(input logic ld, input logic [31:0] a, input logic [1:0] sz,
                     input logic [31:0] d);
    @(posedge CLOCK);
    D_VALID <= 1'b1;
    D_LOAD <= ld;
    D_ADDR <= a;
    D_SIZE <= sz;
    D_DATA <= d;
    D_PC <= 32'h0000_0400;
    @(posedge CLOCK);
    D_VALID <= 1'b0;
    D_ADDR <= ~a;
    D_DATA <= ~d;
  endtask
endmodule
`default_nettype wire

// [verif/bpm_match_tb_top.sv]
// Self-checking testbench of the breakpoint matching block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR at %0t got %h exp %h", $time, a, b); end end

module bpm_match_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic dbg = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  wire logic [31:0] rdat, ipc, dpc, da, dd, epc;
  wire logic ack, iv, il, ids, dv, dl, dds, ib, ik, db, bst, bl, nw, edf;
  wire logic [1:0] dsz;
  int errors = 0;
  int n_checks = 0;

  // ****
  // Clock, design and pipeline
  // ****
  always #12.5 clock = ~clock;

  bpm_match i_bpm_match (.CLOCK(clock), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .DEBUG_MODE(dbg), .I_VALID(iv), .I_PC(ipc), .I_LONG(il),
    .I_DELAY_SLOT(ids), .D_VALID(dv), .D_LOAD(dl), .D_PC(dpc), .D_DELAY_SLOT(dds),
    .D_ADDR(da), .D_SIZE(dsz), .D_DATA(dd), .INST_BREAK(ib), .INST_KILL(ik),
    .DATA_BREAK(db), .BLOCK_STORE(bst), .BLOCK_LOAD(bl), .NO_WRITEBACK(nw),
    .DEBUG_EXCEPTION_PC(epc), .DEBUG_BRANCH_DELAY_FLAG(edf));

  bpm_pipe i_bpm_pipe (.CLOCK(clock), .I_VALID(iv), .I_PC(ipc), .I_LONG(il),
    .I_DELAY_SLOT(ids), .D_VALID(dv), .D_LOAD(dl), .D_PC(dpc), .D_DELAY_SLOT(dds),
    .D_ADDR(da), .D_SIZE(dsz), .D_DATA(dd));

  // ****
  // Bus and pipeline helpers
  // ****
  // Classic cycle: hold everything until ack is sampled high.
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clock);
    while (ack !== 1'b1) @(posedge clock);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  // Break outputs pulse in the cycle after the taking edge.
  task automatic ic(input logic [31:0] pc, input logic lng, input logic ds, input logic e);
    i_bpm_pipe.ins(pc, lng, ds);
    #1;
    `CHK({ib, ik}, {e, e})
  endtask

  // Expected order: data break, block store, block load, no writeback.
  task automatic dc(input logic ld, input logic [31:0] a, input logic [1:0] sz,
                    input logic [31:0] d, input logic [3:0] e);
    i_bpm_pipe.dat(ld, a, sz, d);
    #1;
    `CHK({db, bst, bl, nw}, e)
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rd(12'h108, 32'h0000_0040);
    wr(12'h108, 32'hffff_ffff);
    rd(12'h108, 32'h0000_0075);
    wr(12'h108, 32'h0000_0000);
    rd(12'h208, 32'h0000_0400);
    wr(12'h208, 32'hffff_ffff);
    rd(12'h208, 32'h0003_f7f7);
    rd(12'h0f0, 32'h0000_0000);
    rd(12'h000, 32'h0200_0000);
  endtask

  task automatic t_inst();
    wr(12'h100, 32'h0000_1000);
    wr(12'h104, 32'h0000_000f);
    wr(12'h108, 32'h0000_0001);
    ic(32'h0000_100c, 1'b0, 1'b1, 1'b1);
    `CHK({epc, edf}, {32'h0000_100c, 1'b1})
    ic(32'h0000_1010, 1'b0, 1'b0, 1'b0);
    rd(12'h000, 32'h0200_0001);
    @(posedge clock) dbg <= 1'b1;
    ic(32'h0000_1004, 1'b0, 1'b0, 1'b0);
    @(posedge clock) dbg <= 1'b0;
    wr(12'h000, 32'h0000_0000);
    rd(12'h000, 32'h0200_0000);
    wr(12'h108, 32'h0000_0004);
    ic(32'h0000_1004, 1'b0, 1'b0, 1'b0);
    rd(12'h000, 32'h0200_0001);
    wr(12'h108, 32'h0000_0000);
    // Channel 1 in range mode: upper limit 0x2010, lower 0x2000.
    wr(12'h110, 32'h0000_2010);
    wr(12'h114, 32'h0000_2000);
    wr(12'h118, 32'h0000_0011);
    ic(32'h0000_2008, 1'b0, 1'b0, 1'b1);
    ic(32'h0000_1ffe, 1'b0, 1'b0, 1'b0);
    ic(32'h0000_2012, 1'b0, 1'b0, 1'b0);
    ic(32'h0000_2010, 1'b1, 1'b0, 1'b1);
    wr(12'h118, 32'h0000_0031);
    ic(32'h0000_2012, 1'b0, 1'b0, 1'b1);
    ic(32'h0000_2008, 1'b0, 1'b0, 1'b0);
    ic(32'h0000_2010, 1'b1, 1'b0, 1'b1);
    rd(12'h000, 32'h0200_0003);
    wr(12'h118, 32'h0000_0000);
  endtask

  task automatic t_data();
    wr(12'h200, 32'h0000_3000);
    wr(12'h204, 32'h0000_0000);
    wr(12'h20c, 32'h0000_00ab);
    wr(12'h208, 32'h0000_0001);
    dc(1'b0, 32'h0000_3000, 2'h0, 32'h0000_00ab, 4'hd);
    `CHK({epc, edf}, {32'h0000_0400, 1'b0})
    dc(1'b1, 32'h0000_3000, 2'h0, 32'h0000_00ab, 4'h9);
    dc(1'b1, 32'h0000_3000, 2'h0, 32'h0000_00ac, 4'h0);
    dc(1'b1, 32'h0000_3001, 2'h0, 32'h0000_00ff, 4'h9);
    wr(12'h208, 32'h0000_0003);
    dc(1'b1, 32'h0000_3000, 2'h0, 32'h0000_00ac, 4'h9);
    dc(1'b1, 32'h0000_3000, 2'h0, 32'h0000_00ab, 4'h0);
    wr(12'h208, 32'h0000_00f1);
    dc(1'b1, 32'h0000_3000, 2'h0, 32'h0000_0055, 4'hb);
    rd(12'h004, 32'h0100_0001);
    // Low two lanes ignored: a low halfword misses, a high one hits.
    wr(12'h208, 32'h0000_c0f1);
    dc(1'b1, 32'h0000_3000, 2'h1, 32'h0000_0000, 4'h0);
    dc(1'b1, 32'h0000_3002, 2'h1, 32'h0000_0000, 4'hb);
    // Range: upper 0x400f, lower 0x4002, all lane masks set.
    wr(12'h200, 32'h0000_400f);
    wr(12'h204, 32'h0000_4002);
    wr(12'h208, 32'h0000_01f1);
    dc(1'b1, 32'h0000_4004, 2'h2, 32'h0000_0000, 4'hb);
    dc(1'b1, 32'h0000_4010, 2'h2, 32'h0000_0000, 4'h0);
    dc(1'b1, 32'h0000_4000, 2'h2, 32'h0000_0000, 4'hb);
    wr(12'h208, 32'h0000_03f1);
    dc(1'b1, 32'h0000_4004, 2'h2, 32'h0000_0000, 4'h0);
    dc(1'b1, 32'h0000_4000, 2'h2, 32'h0000_0000, 4'hb);
    dc(1'b0, 32'h0000_4010, 2'h2, 32'h0000_0000, 4'hd);
    @(posedge clock) dbg <= 1'b1;
    dc(1'b0, 32'h0000_4010, 2'h2, 32'h0000_0000, 4'h0);
    @(posedge clock) dbg <= 1'b0;
  endtask

  // ****
  // Sequence, watchdog and verdict
  // ****
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_inst();
    t_data();
    wrap_up();
  end

  // About 180 cycles are expected; a hang is cut off well beyond.
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule
`default_nettype wire
